// [verilog/tws_params.svh]
/*
 * constants of the two-wire serial port: address patterns, reset values, timing counts.
 * assumes a 50 MHz system clock; included by bare name.
 */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
`define TWS_ID_MEM 4'ha
`define TWS_ID_CCR 4'hd
`define TWS_SEL 3'h7
`define TWS_RNW_READ 1'h1
`define TWS_ADDR_RST 16'h0000
`define TWS_MEM_DEPTH 2048
`define TWS_CCR_DEPTH 64
`define TWS_PAGE_BITS 6
`define TWS_CLK_NS 20
`define TWS_PROG_DLY_NS 200
`define TWS_PROG_DLY_CYC ((`TWS_PROG_DLY_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_WC_MS 5
`define TWS_WC_CYC (`TWS_WC_MS * 1000000 / `TWS_CLK_NS)
`define TWS_SCL_QTR 33
`define TWS_FIFO_DEPTH 16
`endif

// [verilog/tws_pkg.sv]
/*
 * types shared by both ends of the two-wire serial port.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package tws_pkg;
	typedef enum {dev_idle, dev_slave, dev_word_hi, dev_word_lo, dev_wdata,
		dev_ack_out, dev_rdata, dev_ack_in} tws_dev_st_e;
	typedef enum {hst_idle, hst_start, hst_sla, hst_ahi, hst_alo, hst_wdat,
		hst_rdat, hst_stop} tws_hst_st_e;
	typedef enum logic [1:0] {op_read, op_random, op_write} tws_op_e;
endpackage : tws_pkg

// [verilog/tws_if.sv]
/*
 * serial clock and open-drain data line joining the host end and the device end.
 * assumes a pull-up: the line is high unless an end drives it low.
 */
`timescale 1ns/1ps
interface tws_if;
	logic scl;
	logic sda;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	modport host(output scl, output host_sda_o, output host_sda_oe, input sda);
	modport dev(input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : tws_if

// [verilog/tws_fifo.sv]
/*
 * synchronous valid/ready fifo with parameter width and depth.
 * assumes one clock; depth is a power of two.
 */
`timescale 1ns/1ps
module tws_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
)(
	input logic clk_i,
	input logic rst_i,
	input logic in_valid_i,
	output logic in_ready_o,
	input logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW:0] wr_reg;
	logic [PW:0] rd_reg;
	wire full = (wr_reg[PW] != rd_reg[PW]) && (wr_reg[PW-1:0] == rd_reg[PW-1:0]);
	wire empty = wr_reg == rd_reg;
	wire push = in_valid_i & ~full;
	wire pop = out_ready_i & ~empty;
	assign in_ready_o = ~full;
	assign out_valid_o = ~empty;
	assign out_data_o = mem_reg[rd_reg[PW-1:0]];

	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_reg[wr_reg[PW-1:0]] <= in_data_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_reg + (PW+1)'(push);
			rd_reg <= rd_reg + (PW+1)'(pop);
		end
	end
endmodule : tws_fifo

// [verilog/tws_slave.sv]
/*
 * device end of the two-wire port: slave addressing, word address load,
 * byte writes with a timed program cycle, and sequential reads.
 * assumes scl and sda arrive asynchronously; both pass two flip-flops.
 */
// What this block does
// - reads start from counter or loaded address
// - keep sending bytes while master acknowledges
// - master ends read with nack, stop
// - read counter advances one per byte sent
// - counter wraps to start of space
// - upper nibble picks memory or register space
// - select bits must equal 111
// - last address bit one reads, zero writes
// - compare seven bits after full byte, acknowledge
// - random read sends two word address bytes
// - counter clears to zero at reset
// - same seven address bits in dummy write, read
// - program state after delay past stop
// - no acknowledge on mismatched address byte
// - release line, sample ack after byte
// - ignore bus while programming is busy
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_slave
	import tws_pkg::*;
#(
	parameter int unsigned MEM_DEPTH = `TWS_MEM_DEPTH,
	parameter int unsigned CCR_DEPTH = `TWS_CCR_DEPTH,
	parameter int unsigned WC_CYC = `TWS_WC_CYC
)(
	input logic clk_i,
	input logic rst_i,
	tws_if.dev bus,
	output logic busy_o,
	output logic [15:0] addr_o,
	output logic ccr_sel_o
);
	localparam int unsigned AW = $clog2(MEM_DEPTH);
	localparam int unsigned CW = $clog2(CCR_DEPTH);
	localparam int unsigned PB = `TWS_PAGE_BITS;
	localparam int unsigned DLY = `TWS_PROG_DLY_CYC;
	localparam int unsigned QW = $clog2(WC_CYC + DLY + 1);

	function automatic logic [15:0] next_addr(input logic [15:0] a, input logic clock_control_register_space);
		logic [15:0] last;
		last = clock_control_register_space ? 16'(CCR_DEPTH - 1) : 16'(MEM_DEPTH - 1);
		next_addr = (a >= last) ? `TWS_ADDR_RST : a + 16'h0001;
	endfunction : next_addr

	////////////////////////////////////////////////////////////////////////
	// pin sampling and bus conditions
	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic scl_d_reg;
	logic sda_d_reg;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_sync_reg <= {scl_sync_reg[0], bus.scl};
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end

	wire scl_s = scl_sync_reg[1];
	wire sda_s = sda_sync_reg[1];
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	////////////////////////////////////////////////////////////////////////
	// byte engine state
	tws_dev_st_e st_reg;
	tws_dev_st_e nxt_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic [7:0] hi_reg;
	logic [3:0] cnt_reg;
	logic oe_reg;
	logic ccr_reg;
	logic acked_reg;
	logic wrote_reg;
	logic [15:0] addr_reg;
	logic [QW-1:0] prog_reg;
	logic [7:0] mem_reg [MEM_DEPTH];
	logic [7:0] ccr_mem_reg [CCR_DEPTH];

	wire rx_st = st_reg inside {dev_slave, dev_word_hi, dev_word_lo, dev_wdata};
	wire byte_in = cnt_reg == 4'h8;
	wire id_mem = sh_reg[7:1] == {`TWS_ID_MEM, `TWS_SEL};
	wire id_ccr = sh_reg[7:1] == {`TWS_ID_CCR, `TWS_SEL};
	wire addr_hit = byte_in & (id_mem | id_ccr);
	wire is_read = sh_reg[0] == `TWS_RNW_READ;
	wire prog_active = prog_reg != '0;
	wire [7:0] rd_byte = ccr_reg ? ccr_mem_reg[addr_reg[CW-1:0]] : mem_reg[addr_reg[AW-1:0]];
	wire [15:0] rd_next = next_addr(addr_reg, ccr_reg);
	// writes roll over inside the page; reads cross pages
	wire [15:0] wr_next = {addr_reg[15:PB], addr_reg[PB-1:0] + PB'(1)};
	wire wr_byte = scl_fall & (st_reg == dev_wdata) & byte_in;
	wire fall_rx_done = scl_fall & rx_st & byte_in;
	wire load_tx = scl_fall & (((st_reg == dev_ack_out) & (nxt_reg == dev_rdata))
		| ((st_reg == dev_ack_in) & acked_reg));

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = oe_reg;
	assign busy_o = prog_active & (prog_reg <= QW'(WC_CYC));
	assign addr_o = addr_reg;
	assign ccr_sel_o = ccr_reg;

	////////////////////////////////////////////////////////////////////////
	// program cycle timer: delay after stop, then the write cycle time
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			prog_reg <= '0;
		else if (stop_det & wrote_reg)
			prog_reg <= QW'(WC_CYC + DLY);
		else if (prog_active)
			prog_reg <= prog_reg - QW'(1);
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_byte & ~ccr_reg)
			mem_reg[addr_reg[AW-1:0]] <= sh_reg;
		if (wr_byte & ccr_reg)
			ccr_mem_reg[addr_reg[CW-1:0]] <= sh_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// address counter
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			addr_reg <= `TWS_ADDR_RST;
		else if (fall_rx_done & (st_reg == dev_word_lo))
			addr_reg <= {hi_reg, sh_reg};
		else if (wr_byte)
			addr_reg <= wr_next;
		else if (load_tx)
			addr_reg <= rd_next;
	end

	////////////////////////////////////////////////////////////////////////
	// bit and byte sequencing
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg <= dev_idle;
			nxt_reg <= dev_idle;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			hi_reg <= 8'h00;
			cnt_reg <= 4'h0;
			oe_reg <= 1'b0;
			ccr_reg <= 1'b0;
			acked_reg <= 1'b0;
			wrote_reg <= 1'b0;
		end
		else if (stop_det)
		begin
			st_reg <= dev_idle;
			oe_reg <= 1'b0;
			wrote_reg <= 1'b0;
		end
		else if (start_det)
		begin
			// a busy device stays deaf so the master can poll for the ack
			st_reg <= prog_active ? dev_idle : dev_slave;
			cnt_reg <= 4'h0;
			oe_reg <= 1'b0;
		end
		else if (scl_rise)
		begin
			if (rx_st)
			begin
				sh_reg <= {sh_reg[6:0], sda_s};
				cnt_reg <= cnt_reg + 4'h1;
			end
			else if (st_reg == dev_rdata)
				cnt_reg <= cnt_reg + 4'h1;
			else if (st_reg == dev_ack_in)
				acked_reg <= ~sda_s;
		end
		else if (load_tx)
		begin
			oe_reg <= ~rd_byte[7];
			tx_reg <= {rd_byte[6:0], 1'b0};
			cnt_reg <= 4'h0;
			st_reg <= dev_rdata;
		end
		else if (fall_rx_done)
		begin
			oe_reg <= 1'b1;
			st_reg <= dev_ack_out;
			unique case (st_reg)
				dev_slave:
				begin
					if (addr_hit)
					begin
						ccr_reg <= id_ccr;
						nxt_reg <= is_read ? dev_rdata : dev_word_hi;
					end
					else
					begin
						oe_reg <= 1'b0;
						st_reg <= dev_idle;
					end
				end
				dev_word_hi:
				begin
					hi_reg <= sh_reg;
					nxt_reg <= dev_word_lo;
				end
				dev_word_lo:
					nxt_reg <= dev_wdata;
				dev_wdata:
				begin
					wrote_reg <= 1'b1;
					nxt_reg <= dev_wdata;
				end
			endcase
		end
		else if (scl_fall)
		begin
			unique case (st_reg)
				dev_ack_out:
				begin
					oe_reg <= 1'b0;
					cnt_reg <= 4'h0;
					st_reg <= nxt_reg;
				end
				dev_rdata:
				begin
					if (byte_in)
					begin
						oe_reg <= 1'b0;
						st_reg <= dev_ack_in;
					end
					else
					begin
						oe_reg <= ~tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
				dev_ack_in:
					st_reg <= dev_idle;
				dev_idle, dev_slave, dev_word_hi, dev_word_lo, dev_wdata:
					st_reg <= st_reg;
			endcase
		end
	end
endmodule : tws_slave

// [verilog/tws_master.sv]
/*
 * host end of the two-wire port: makes scl from a divider, runs current
 * address reads, random reads and byte writes, and queues read bytes.
 * assumes sda is asynchronous to clk_i; it passes two flip-flops.
 */
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_master
	import tws_pkg::*;
#(
	parameter int unsigned QTR = `TWS_SCL_QTR,
	parameter int unsigned FIFO_DEPTH = `TWS_FIFO_DEPTH
)(
	input logic clk_i,
	input logic rst_i,
	tws_if.host bus,
	input logic cmd_valid_i,
	output logic cmd_ready_o,
	input tws_op_e cmd_op_i,
	input logic cmd_ccr_i,
	input logic [15:0] cmd_addr_i,
	input logic [7:0] cmd_wdata_i,
	input logic [7:0] cmd_len_i,
	output logic rd_valid_o,
	input logic rd_ready_i,
	output logic [7:0] rd_data_o,
	output logic done_o,
	output logic nack_o
);
	localparam int unsigned DW = $clog2(QTR);
	tws_hst_st_e st_reg;
	tws_op_e op_reg;
	logic ccr_reg;
	logic second_reg;
	logic [15:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] left_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [DW-1:0] div_reg;
	logic [1:0] ph_reg;
	logic [3:0] bit_reg;
	logic scl_reg;
	logic oe_reg;
	logic [1:0] sda_sync_reg;

	wire tick = div_reg == DW'(QTR - 1);
	wire push_v = tick & (st_reg == hst_rdat) & (bit_reg == 4'h7) & (ph_reg == 2'h3);
	wire push_rdy;
	// a full fifo freezes the divider before scl falls on the last data bit, stalling the read
	wire adv = tick & ~(push_v & ~push_rdy);
	wire byte_done = adv & (ph_reg == 2'h3) & (bit_reg == 4'h8);
	wire rnw = (op_reg == op_read) | second_reg;
	wire [3:0] id = ccr_reg ? `TWS_ID_CCR : `TWS_ID_MEM;
	wire [7:0] sla = {id, `TWS_SEL, rnw};
	wire ack_send = left_reg > 8'h01;
	wire accept = cmd_valid_i & (st_reg == hst_idle);

	assign cmd_ready_o = st_reg == hst_idle;
	assign bus.scl = scl_reg;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = oe_reg;

	tws_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(push_v),
		.in_ready_o(push_rdy),
		.in_data_i(rx_reg),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_data_o(rd_data_o)
	);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sda_sync_reg <= 2'h3;
			div_reg <= '0;
		end
		else
		begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			if (st_reg == hst_idle | adv)
				div_reg <= '0;
			else if (~tick)
				div_reg <= div_reg + DW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// quarter-bit sequencing: 0 set data, 1 scl high, 2 sample, 3 scl low
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_reg <= hst_idle;
			op_reg <= op_read;
			ccr_reg <= 1'b0;
			second_reg <= 1'b0;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			left_reg <= 8'h00;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			scl_reg <= 1'b1;
			oe_reg <= 1'b0;
			done_o <= 1'b0;
			nack_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			nack_o <= 1'b0;
			if (accept)
			begin
				op_reg <= cmd_op_i;
				ccr_reg <= cmd_ccr_i;
				addr_reg <= cmd_addr_i;
				wdata_reg <= cmd_wdata_i;
				left_reg <= (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
				second_reg <= 1'b0;
				ph_reg <= 2'h0;
				bit_reg <= 4'h0;
				st_reg <= hst_start;
			end
			else if (adv)
			begin
				ph_reg <= ph_reg + 2'h1;
				unique case (ph_reg)
					2'h0:
						if (st_reg == hst_start)
							oe_reg <= 1'b0;
						else if (st_reg == hst_stop)
							oe_reg <= 1'b1;
						else if (bit_reg == 4'h8)
							oe_reg <= (st_reg == hst_rdat) & ack_send;
						else
							oe_reg <= (st_reg != hst_rdat) & ~tx_reg[7];
					2'h1:
						scl_reg <= 1'b1;
					2'h2:
						if (st_reg == hst_start)
							oe_reg <= 1'b1;
						else if (st_reg == hst_stop)
							oe_reg <= 1'b0;
						else
							rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
					2'h3:
						if (st_reg != hst_stop)
							scl_reg <= 1'b0;
				endcase
				if (ph_reg == 2'h3)
				begin
					bit_reg <= byte_done ? 4'h0 : bit_reg + 4'h1;
					tx_reg <= {tx_reg[6:0], 1'b0};
					if (st_reg == hst_start)
					begin
						bit_reg <= 4'h0;
						tx_reg <= sla;
						st_reg <= hst_sla;
					end
					else if (st_reg == hst_stop)
					begin
						done_o <= 1'b1;
						st_reg <= hst_idle;
					end
				end
				if (byte_done)
				begin
					unique case (st_reg)
						hst_sla:
							if (rx_reg[0])
							begin
								nack_o <= 1'b1;
								st_reg <= hst_stop;
							end
							else if (rnw)
								st_reg <= hst_rdat;
							else
							begin
								tx_reg <= addr_reg[15:8];
								st_reg <= hst_ahi;
							end
						hst_ahi:
						begin
							tx_reg <= addr_reg[7:0];
							st_reg <= hst_alo;
						end
						hst_alo:
							if (op_reg == op_random)
							begin
								second_reg <= 1'b1;
								st_reg <= hst_start;
							end
							else
							begin
								tx_reg <= wdata_reg;
								st_reg <= (op_reg == op_write) ? hst_wdat : hst_stop;
							end
						hst_rdat:
						begin
							left_reg <= left_reg - 8'h01;
							st_reg <= ack_send ? hst_rdat : hst_stop;
						end
						hst_idle, hst_start, hst_wdat, hst_stop:
							st_reg <= hst_stop;
					endcase
				end
			end
		end
	end
endmodule : tws_master

// [test/tws_properties.sv]
/*
 * concurrent checks on the device end of the two-wire link.
 * assumes the bench wires it to the interface that joins host and device.
 */
`timescale 1ns/1ps
module tws_properties #(
	parameter int unsigned WC_CYC = 200
)(
	input logic clk_i,
	input logic rst_i,
	input logic scl,
	input logic sda,
	input logic dev_sda_o,
	input logic dev_sda_oe,
	input logic busy_o,
	input logic [15:0] addr_o
);
	// length of the current program cycle in clocks
	logic [31:0] busy_cnt_reg;
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			busy_cnt_reg <= 32'h0;
		else
			busy_cnt_reg <= busy_o ? busy_cnt_reg + 32'h1 : 32'h0;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_rst_clear;
		$fell(rst_i) |-> addr_o == 16'h0000 && !busy_o && !dev_sda_oe;
	endproperty
	a_rst_clear: assert property (p_rst_clear)
		else $error("device not idle after reset");
	property p_busy_len;
		$fell(busy_o) |-> busy_cnt_reg == WC_CYC;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("program cycle length wrong");
	// the line must have shown a stop some clocks before programming begins
	property p_prog_delay;
		$rose(busy_o) |-> $past(scl && sda, 6);
	endproperty
	a_prog_delay: assert property (p_prog_delay)
		else $error("program cycle began without a stop");
	property p_busy_single;
		$fell(busy_o) |=> !busy_o [*8];
	endproperty
	a_busy_single: assert property (p_busy_single)
		else $error("program cycle restarted at once");
	property p_busy_quiet;
		busy_o |-> !dev_sda_oe;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("device drove the line while programming");
	property p_addr_frozen;
		busy_o && $past(busy_o) |-> $stable(addr_o);
	endproperty
	a_addr_frozen: assert property (p_addr_frozen)
		else $error("counter moved while programming");
	property p_change_scl_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_change_scl_low: assert property (p_change_scl_low)
		else $error("device changed the line while clock high");
	property p_open_drain;
		dev_sda_oe |-> !dev_sda_o && !sda;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("device drive is not a low level");
endmodule : tws_properties

// [test/tb_top.sv]
/*
 * bench joining host and device ends, plus a second device probed by hand.
 * assumes the design files compile first; clock 50 MHz.
 */
`timescale 1ns/1ps
module tb_top
	import tws_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	tws_op_e cmd_op_i = op_read;
	logic cmd_ccr_i = 1'b0;
	logic [15:0] cmd_addr_i = 16'h0000;
	logic [7:0] cmd_wdata_i = 8'h00;
	logic [7:0] cmd_len_i = 8'h01;
	logic rd_ready_i = 1'b0;
	logic cmd_ready_o, rd_valid_o, done_o, nack_o, busy_o, ccr_sel_o, nk;
	logic [7:0] rd_data_o;
	logic [15:0] addr_o;
	logic [7:0] mexp [2048];
	logic [7:0] cexp [64];
	logic [7:0] q [$];
	logic stall = 1'b0;
	int failures = 0;
	int checks = 0;
	int nacks = 0;
	integer seed = 44;
	always #10 clk_i = ~clk_i;
	tws_if i_tws_if();
	tws_if i_tws_if_b();
	tws_master #(.QTR(4), .FIFO_DEPTH(16)) i_tws_master(.clk_i(clk_i), .rst_i(rst_i),
		.bus(i_tws_if), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
		.cmd_op_i(cmd_op_i), .cmd_ccr_i(cmd_ccr_i), .cmd_addr_i(cmd_addr_i),
		.cmd_wdata_i(cmd_wdata_i), .cmd_len_i(cmd_len_i), .rd_valid_o(rd_valid_o),
		.rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .done_o(done_o), .nack_o(nack_o));
	tws_slave #(.WC_CYC(200)) i_tws_slave(.clk_i(clk_i), .rst_i(rst_i), .bus(i_tws_if),
		.busy_o(busy_o), .addr_o(addr_o), .ccr_sel_o(ccr_sel_o));
	tws_slave #(.WC_CYC(200)) i_tws_slave_b(.clk_i(clk_i), .rst_i(rst_i), .bus(i_tws_if_b),
		.busy_o(), .addr_o(), .ccr_sel_o());
	tws_properties #(.WC_CYC(200)) i_tws_properties(.clk_i(clk_i), .rst_i(rst_i),
		.scl(i_tws_if.scl), .sda(i_tws_if.sda), .dev_sda_o(i_tws_if.dev_sda_o),
		.dev_sda_oe(i_tws_if.dev_sda_oe), .busy_o(busy_o), .addr_o(addr_o));
	////////////////////////////////////////////////////////////////////////////////
	task test_done();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wt
	task cmd(input tws_op_e op, input logic clock_control_register_space, input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] len, output logic nack);
		int n;
		nack = 1'b0;
		n = 0;
		cmd_op_i = op;
		cmd_ccr_i = clock_control_register_space;
		cmd_addr_i = a;
		cmd_wdata_i = d;
		cmd_len_i = len;
		cmd_valid_i = 1'b1;
		while (cmd_ready_o !== 1'b1)
			wt(1);
		wt(1);
		cmd_valid_i = 1'b0;
		while (done_o !== 1'b1 && n < 20000)
		begin
			nack = nack | (nack_o === 1'b1);
			n++;
			wt(1);
		end
		// a command that never reaches its stop counts as a mismatch
		chk("command done", 16'h0001, {15'h0, done_o});
	endtask : cmd
	// a refused write means the device is still programming: poll again
	task wr(input logic clock_control_register_space, input logic [15:0] a);
		logic [7:0] d;
		d = 8'($random(seed));
		if (clock_control_register_space)
			cexp[a[5:0]] = d;
		else
			mexp[a[10:0]] = d;
		nk = 1'b1;
		while (nk)
		begin
			cmd(op_write, clock_control_register_space, a, d, 8'h01, nk);
			nacks += int'(nk);
		end
	endtask : wr
	task rd(input tws_op_e op, input logic clock_control_register_space, input logic [15:0] a, input logic [7:0] len);
		for (int i = 0; i < len; i++)
			q.push_back(clock_control_register_space ? cexp[6'(a + i)] : mexp[11'(a + i)]);
		cmd(op, clock_control_register_space, a, 8'h00, len, nk);
		chk("read slave byte nack", 16'h0000, {15'h0, nk});
	endtask : rd
	// hand-made slave byte on the second link, then a stop
	task probe(input logic [7:0] b, input logic exp_ack);
		i_tws_if_b.host_sda_oe = 1'b1;
		wt(8);
		i_tws_if_b.scl = 1'b0;
		// 160 ns bit period: four clocks low, four clocks high
		for (int i = 7; i >= -1; i--)
		begin
			i_tws_if_b.host_sda_oe = (i >= 0) ? !b[i[2:0]] : 1'b0;
			wt(2);
			i_tws_if_b.scl = 1'b1;
			wt(2);
			if (i < 0)
				chk("probe ack", {15'h0, exp_ack}, {15'h0, !i_tws_if_b.sda});
			wt(2);
			i_tws_if_b.scl = 1'b0;
			wt(2);
		end
		i_tws_if_b.host_sda_oe = 1'b1;
		wt(2);
		i_tws_if_b.scl = 1'b1;
		wt(2);
		i_tws_if_b.host_sda_oe = 1'b0;
		wt(16);
	endtask : probe
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i)
	begin
		#1;
		rd_ready_i = !stall && ($random(seed) % 4 != 0);
	end
	always @(posedge clk_i)
	begin
		if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
		begin
			if (q.size() == 0)
				chk("read byte count", 16'h0000, 16'h0001);
			else
				chk("read byte", {8'h00, q.pop_front()}, {8'h00, rd_data_o});
		end
	end
	initial
	begin
		wt(90000);
		failures++;
		test_done();
	end
	initial
	begin
		i_tws_if_b.scl = 1'b1;
		i_tws_if_b.host_sda_o = 1'b0;
		i_tws_if_b.host_sda_oe = 1'b0;
		wt(8);
		rst_i = 1'b0;
		chk("counter after reset", 16'h0000, addr_o);
		probe(8'hae, 1'b1);
		probe(8'hde, 1'b1);
		probe(8'hbe, 1'b0);
		probe(8'hac, 1'b0);
		for (int i = 0; i < 22; i++)
			wr(1'b0, 16'((16'h07f0 + i) % 2048));
		wr(1'b1, 16'h003f);
		wr(1'b1, 16'h0000);
		chk("polls refused while busy", 16'h0001, {15'h0, nacks > 0});
		// the last write is still programming: a read now would go unacknowledged
		wt(250);
		stall = 1'b1;
		fork
			rd(op_random, 1'b0, 16'h07f0, 8'd20);
			begin
				wt(3000);
				chk("fifo holds while stalled", 16'h0001, {15'h0, rd_valid_o});
				stall = 1'b0;
			end
		join
		chk("counter after wrap", 16'h0004, addr_o);
		chk("space select", 16'h0000, {15'h0, ccr_sel_o});
		rd(op_read, 1'b0, 16'h0004, 8'd2);
		rd(op_random, 1'b1, 16'h003f, 8'd2);
		chk("space select", 16'h0001, {15'h0, ccr_sel_o});
		wt(20);
		chk("bytes outstanding", 16'h0000, 16'(q.size()));
		test_done();
	end
endmodule : tb_top
